// file: pkg/pvc_pkg.sv
// Package of offsets, field layouts, reset values, timings and types for the port control bank.
package pvc_pkg;
	localparam logic [7:0] ADDR_VEND_STATUS = 8'h90;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h92;
	localparam logic [7:0] ADDR_GEN_CTRL = 8'h94;
	localparam logic [7:0] ADDR_TX_CTRL = 8'h95;
	localparam logic [7:0] ADDR_RX_CTRL = 8'h96;
	localparam logic [7:0] ADDR_RX_STATUS = 8'h97;

	localparam logic [7:0] RST_VEND_STATUS = 8'h00;
	localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
	localparam logic [7:0] RST_GEN_CTRL = 8'h04;
	localparam logic [7:0] RST_TX_CTRL = 8'h00;
	localparam logic [7:0] RST_RX_CTRL = 8'h00;

	localparam int BIT_TIMER = 4;
	localparam int BIT_FAULT = 3;
	localparam int BIT_OTEMP = 2;
	localparam logic [7:0] EVENT_BITS = 8'h1C;
	localparam logic [7:0] IRQ_ENABLE_WMASK = 8'h1F;

	localparam int BIT_CLEAR_MODE = 7;
	localparam int BIT_PHY_RESET = 6;
	localparam int BIT_SOFT_RESET = 5;
	localparam int BIT_SAMPLE_POLICY = 4;
	localparam int RATE_LSB = 2;
	localparam int DUTY_LSB = 0;
	localparam logic [7:0] GEN_CTRL_WMASK = 8'h9F;

	localparam int BIT_BIST_SEL = 2;
	localparam int BIT_FRS = 1;
	localparam logic [7:0] TX_CTRL_WMASK = 8'h04;

	localparam int BIT_RX_OVERRIDE = 2;
	localparam logic [7:0] RX_CTRL_WMASK = 8'h0F;
	localparam logic [7:0] RX_STATUS_MASK = 8'h0F;

	localparam int CLOCK_PERIOD_NS = 8;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS / CLOCK_PERIOD_NS;
	localparam int SAMPLE_MS_00 = 1;
	localparam int SAMPLE_MS_01 = 2;
	localparam int SAMPLE_MS_10 = 8;
	localparam int SAMPLE_MS_11 = 16;
	localparam int SAMPLE_CNT_W = 22;

	localparam logic [6:0] DUTY_PCT_00 = 7'h1E;
	localparam logic [6:0] DUTY_PCT_01 = 7'h0A;
	localparam logic [6:0] DUTY_PCT_10 = 7'h32;
	localparam logic [6:0] DUTY_PCT_11 = 7'h3C;

	localparam int PHY_RESET_CYCLES = 8;
	localparam int SOFT_RESET_CYCLES = 16;

	typedef enum logic [1:0] {PVC_LVL_SNK, PVC_LVL_SRC, PVC_LVL_NEU} pvc_level_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pvc_reg_req_t;

	typedef struct packed {
		pvc_level_t high_level;
		pvc_level_t low_level;
	} pvc_rx_thresh_t;

	typedef struct packed {
		logic slow_timer;
		logic overtemp;
	} pvc_events_t;
endpackage

// file: rtl/pvc_pulse_seq.sv
// Self-timed reset sequencer: holds busy for a fixed count after a start request.
`timescale 1ns/100ps
module pvc_pulse_seq #(
	parameter int HOLD_CYCLES = 8
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	output logic busy_out,
	output logic done_out
);
	import pvc_pkg::*;

	localparam int CW = $clog2(HOLD_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES - 1);

	typedef enum logic {PVC_SEQ_IDLE, PVC_SEQ_HOLD} pvc_seq_t;

	pvc_seq_t state_reg;
	logic [CW-1:0] count_reg;

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= PVC_SEQ_IDLE;
			count_reg <= '0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			case (state_reg)
				PVC_SEQ_IDLE: begin
					count_reg <= '0;
					if (start_in) begin
						state_reg <= PVC_SEQ_HOLD;
					end
				end
				PVC_SEQ_HOLD: begin
					if (count_reg == LAST) begin
						state_reg <= PVC_SEQ_IDLE;
						done_out <= 1'b1;
					end
					count_reg <= count_reg + CW'(1);
				end
				default: begin
					state_reg <= PVC_SEQ_IDLE;
				end
			endcase
		end
	end

	assign busy_out = (state_reg == PVC_SEQ_HOLD);
endmodule

// file: rtl/pvc_regs.sv
// Vendor control and status register bank of the port controller with PD physical layer.
`timescale 1ns/100ps
module pvc_regs #(
	parameter int MS_CYCLES_P = pvc_pkg::MS_CYCLES
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input pvc_pkg::pvc_reg_req_t reg_req_in,
	output logic [7:0] reg_rdata_out,
	input pvc_pkg::pvc_events_t events_in,
	input wire logic channel_above_limit_in,
	input wire logic unattached_in,
	input wire logic dual_role_toggling_in,
	input wire logic toggle_imminent_in,
	input wire logic power_role_source_in,
	input wire logic [3:0] rx_status_in,
	input wire logic frs_sent_in,
	output logic vendor_irq_out,
	output logic alert_clear_by_read_out,
	output logic phy_hard_reset_out,
	output logic whole_device_reset_out,
	output logic cc_sample_tick_out,
	output logic [6:0] toggle_source_share_out,
	output logic bist_continuous_out,
	output logic frs_transmit_out,
	output pvc_pkg::pvc_rx_thresh_t rx_thresh_out
);
	import pvc_pkg::*;

	function automatic logic hit(input pvc_reg_req_t req, input logic [7:0] addr);
		hit = (req.addr == addr);
	endfunction

	function automatic logic [SAMPLE_CNT_W-1:0] interval_last(input logic [1:0] sel);
		int ms;
		ms = SAMPLE_MS_00;
		case (sel)
			2'h0: ms = SAMPLE_MS_00;
			2'h1: ms = SAMPLE_MS_01;
			2'h2: ms = SAMPLE_MS_10;
			default: ms = SAMPLE_MS_11;
		endcase
		interval_last = SAMPLE_CNT_W'(ms * MS_CYCLES_P - 1);
	endfunction

	logic [7:0] status_reg;
	logic [7:0] irq_en_reg;
	logic [7:0] gen_ctrl_reg;
	logic [7:0] tx_ctrl_reg;
	logic [7:0] rx_ctrl_reg;
	logic frs_reg;
	logic limit_meta_reg;
	logic limit_sync_reg;
	logic [SAMPLE_CNT_W-1:0] sample_cnt_reg;
	logic [7:0] status_set;
	logic [7:0] status_clr;
	logic [7:0] rdata_next;
	logic wr_en;
	logic phy_busy;
	logic soft_busy;
	logic soft_done;
	logic clear_by_read;

	pvc_pulse_seq #(.HOLD_CYCLES(PHY_RESET_CYCLES)) u_phy_seq (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.start_in(reg_req_in.wr && hit(reg_req_in, ADDR_GEN_CTRL) &&
			reg_req_in.wdata[BIT_PHY_RESET]),
		.busy_out(phy_busy),
		.done_out()
	);

	pvc_pulse_seq #(.HOLD_CYCLES(SOFT_RESET_CYCLES)) u_soft_seq (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.start_in(reg_req_in.wr && hit(reg_req_in, ADDR_GEN_CTRL) &&
			reg_req_in.wdata[BIT_SOFT_RESET]),
		.busy_out(soft_busy),
		.done_out(soft_done)
	);

	// Writes are ignored while the soft reset holds the bank at its defaults, except that a phy reset bit still starts its sequencer.
	assign wr_en = reg_req_in.wr && !soft_busy;
	assign clear_by_read = gen_ctrl_reg[BIT_CLEAR_MODE];
	assign alert_clear_by_read_out = clear_by_read;
	assign phy_hard_reset_out = phy_busy;
	assign whole_device_reset_out = soft_busy;

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			limit_meta_reg <= 1'b0;
			limit_sync_reg <= 1'b0;
		end else begin
			limit_meta_reg <= channel_above_limit_in;
			limit_sync_reg <= limit_meta_reg;
		end
	end

	always_comb begin
		status_set = '0;
		status_set[BIT_TIMER] = events_in.slow_timer;
		status_set[BIT_OTEMP] = events_in.overtemp;
		status_set[BIT_FAULT] = limit_sync_reg && unattached_in;
		status_clr = '0;
		if (wr_en && hit(reg_req_in, ADDR_VEND_STATUS) && !clear_by_read) begin
			status_clr = reg_req_in.wdata & EVENT_BITS;
		end else if (reg_req_in.rd && hit(reg_req_in, ADDR_VEND_STATUS) && clear_by_read) begin
			status_clr = status_reg;
		end
	end

	// A flag raised in the same cycle as its clear survives.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			status_reg <= RST_VEND_STATUS;
		end else if (soft_busy) begin
			status_reg <= RST_VEND_STATUS;
		end else begin
			status_reg <= ((status_reg & ~status_clr) | status_set) & EVENT_BITS;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_en_reg <= RST_IRQ_ENABLE;
			gen_ctrl_reg <= RST_GEN_CTRL;
			tx_ctrl_reg <= RST_TX_CTRL;
			rx_ctrl_reg <= RST_RX_CTRL;
		end else if (soft_busy) begin
			irq_en_reg <= RST_IRQ_ENABLE;
			gen_ctrl_reg <= RST_GEN_CTRL;
			tx_ctrl_reg <= RST_TX_CTRL;
			rx_ctrl_reg <= RST_RX_CTRL;
		end else if (wr_en) begin
			if (hit(reg_req_in, ADDR_IRQ_ENABLE)) begin
				irq_en_reg <= reg_req_in.wdata & IRQ_ENABLE_WMASK;
			end
			if (hit(reg_req_in, ADDR_GEN_CTRL)) begin
				gen_ctrl_reg <= reg_req_in.wdata & GEN_CTRL_WMASK;
			end
			if (hit(reg_req_in, ADDR_TX_CTRL)) begin
				tx_ctrl_reg <= reg_req_in.wdata & TX_CTRL_WMASK;
			end
			if (hit(reg_req_in, ADDR_RX_CTRL)) begin
				rx_ctrl_reg <= reg_req_in.wdata & RX_CTRL_WMASK;
			end
		end
	end

	// Software sets the swap request; the transmitter clears it once sent, set winning.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			frs_reg <= 1'b0;
		end else if (soft_busy) begin
			frs_reg <= 1'b0;
		end else if (wr_en && hit(reg_req_in, ADDR_TX_CTRL) && reg_req_in.wdata[BIT_FRS]) begin
			frs_reg <= 1'b1;
		end else if (frs_sent_in) begin
			frs_reg <= 1'b0;
		end
	end

	always_comb begin
		rdata_next = '0;
		case (reg_req_in.addr)
			ADDR_VEND_STATUS: rdata_next = status_reg;
			ADDR_IRQ_ENABLE: rdata_next = irq_en_reg;
			ADDR_GEN_CTRL: begin
				rdata_next = gen_ctrl_reg;
				rdata_next[BIT_PHY_RESET] = phy_busy;
				rdata_next[BIT_SOFT_RESET] = soft_busy;
			end
			ADDR_TX_CTRL: begin
				rdata_next = tx_ctrl_reg;
				rdata_next[BIT_FRS] = frs_reg;
			end
			ADDR_RX_CTRL: rdata_next = rx_ctrl_reg;
			ADDR_RX_STATUS: rdata_next = {4'h0, rx_status_in} & RX_STATUS_MASK;
			default: rdata_next = '0;
		endcase
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= '0;
		end else if (reg_req_in.rd) begin
			reg_rdata_out <= rdata_next;
		end
	end

	// Sampling runs only while toggling unattached; policy 1 follows the toggler's warning.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sample_cnt_reg <= '0;
			cc_sample_tick_out <= 1'b0;
		end else if (!dual_role_toggling_in || !unattached_in || soft_busy) begin
			sample_cnt_reg <= '0;
			cc_sample_tick_out <= 1'b0;
		end else if (gen_ctrl_reg[BIT_SAMPLE_POLICY]) begin
			sample_cnt_reg <= '0;
			cc_sample_tick_out <= toggle_imminent_in;
		end else if (sample_cnt_reg >= interval_last(gen_ctrl_reg[RATE_LSB+:2])) begin
			sample_cnt_reg <= '0;
			cc_sample_tick_out <= 1'b1;
		end else begin
			sample_cnt_reg <= sample_cnt_reg + SAMPLE_CNT_W'(1);
			cc_sample_tick_out <= 1'b0;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			vendor_irq_out <= 1'b0;
			toggle_source_share_out <= DUTY_PCT_00;
			bist_continuous_out <= 1'b0;
			frs_transmit_out <= 1'b0;
			rx_thresh_out <= {PVC_LVL_SNK, PVC_LVL_SNK};
		end else begin
			vendor_irq_out <= |(status_reg & irq_en_reg & EVENT_BITS);
			case (gen_ctrl_reg[DUTY_LSB+:2])
				2'h0: toggle_source_share_out <= DUTY_PCT_00;
				2'h1: toggle_source_share_out <= DUTY_PCT_01;
				2'h2: toggle_source_share_out <= DUTY_PCT_10;
				default: toggle_source_share_out <= DUTY_PCT_11;
			endcase
			bist_continuous_out <= tx_ctrl_reg[BIT_BIST_SEL];
			frs_transmit_out <= frs_reg;
			if (!rx_ctrl_reg[BIT_RX_OVERRIDE]) begin
				rx_thresh_out <= power_role_source_in ? {PVC_LVL_SRC, PVC_LVL_SRC} :
					{PVC_LVL_SNK, PVC_LVL_SNK};
			end else begin
				case (rx_ctrl_reg[1:0])
					2'h0: rx_thresh_out <= {PVC_LVL_SNK, PVC_LVL_SNK};
					2'h1: rx_thresh_out <= {PVC_LVL_SRC, PVC_LVL_SRC};
					2'h2: rx_thresh_out <= {PVC_LVL_NEU, PVC_LVL_NEU};
					default: rx_thresh_out <= {PVC_LVL_SNK, PVC_LVL_SRC};
				endcase
			end
		end
	end

	chk_irq_blocked: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		((irq_en_reg & EVENT_BITS) == 8'h00) |=> !vendor_irq_out)
		else $error("interrupt raised with all events disabled");

	chk_flag_sets_masked: assert property (@(posedge clock_in)
		disable iff (!rst_n_in || soft_busy)
		(events_in.slow_timer && !soft_busy) |=> status_reg[BIT_TIMER])
		else $error("timer event did not set its flag");

	chk_write_one_clear: assert property (@(posedge clock_in)
		disable iff (!rst_n_in)
		(reg_req_in.wr && !soft_busy && reg_req_in.addr == ADDR_VEND_STATUS &&
		!clear_by_read && reg_req_in.wdata[BIT_TIMER] && !events_in.slow_timer)
		|=> !status_reg[BIT_TIMER])
		else $error("write of one did not clear the timer flag");

	chk_read_auto_clear: assert property (@(posedge clock_in)
		disable iff (!rst_n_in)
		(reg_req_in.rd && reg_req_in.addr == ADDR_VEND_STATUS && clear_by_read &&
		!reg_req_in.wr && !events_in.overtemp) |=> !status_reg[BIT_OTEMP])
		else $error("read did not clear the overtemp flag");

	chk_phy_reset_span: assert property (@(posedge clock_in)
		disable iff (!rst_n_in)
		(reg_req_in.wr && reg_req_in.addr == ADDR_GEN_CTRL &&
		reg_req_in.wdata[BIT_PHY_RESET] && !phy_busy)
		|=> phy_hard_reset_out [*8] ##1 !phy_hard_reset_out)
		else $error("phy reset did not last eight cycles");

	chk_soft_reset_default: assert property (@(posedge clock_in)
		disable iff (!rst_n_in)
		soft_done |-> (irq_en_reg == RST_IRQ_ENABLE && gen_ctrl_reg == RST_GEN_CTRL &&
		rx_ctrl_reg == RST_RX_CTRL && status_reg == RST_VEND_STATUS))
		else $error("soft reset left a register off its default");

	chk_sample_policy: assert property (@(posedge clock_in)
		disable iff (!rst_n_in)
		(gen_ctrl_reg[BIT_SAMPLE_POLICY] && !toggle_imminent_in) |=> !cc_sample_tick_out)
		else $error("sample taken outside a toggle warning");

	chk_role_threshold: assert property (@(posedge clock_in)
		disable iff (!rst_n_in)
		(!rx_ctrl_reg[BIT_RX_OVERRIDE] && power_role_source_in)
		|=> rx_thresh_out.low_level == PVC_LVL_SRC)
		else $error("threshold did not follow the source role");

	chk_frs_held: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(frs_reg && !frs_sent_in && !soft_busy) |=> frs_reg ##1 frs_transmit_out)
		else $error("swap request dropped before it was sent");
endmodule

// file: verification/pvc_host_model.sv
// Model of the port-manager processor issuing single-byte register accesses.
`timescale 1ns/100ps
module pvc_host_model (
	input wire logic clock_in,
	input wire logic [7:0] rdata_in,
	output pvc_pkg::pvc_reg_req_t req_out
);
	import pvc_pkg::*;
	initial begin
		req_out = '0;
	end
	// An idle cycle follows each access, so strobes never meet in one time step.
	task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
		output logic [7:0] rdata);
		@(negedge clock_in);
		req_out = '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
		@(negedge clock_in);
		rdata = rdata_in;
		req_out = '0;
	endtask
endmodule

// file: verification/pvc_regs_test.sv
// Self-checking bench for the port control register bank.
`timescale 1ns/100ps
module pvc_regs_test;
	import pvc_pkg::*;
	localparam int MS = 10;
	logic clock_in, rst_n_in, above, unatt, toggling, imminent, role_src, frs_sent;
	logic irq, clr_rd, phy_rst, dev_rst, tick, bist, frs;
	logic [3:0] rx_status;
	logic [6:0] share;
	logic [7:0] rdata;
	pvc_reg_req_t req;
	pvc_events_t events;
	pvc_rx_thresh_t thresh;
	int failures, cmp_count, cycles;
	pvc_host_model host_u (.clock_in(clock_in), .rdata_in(rdata), .req_out(req));
	pvc_regs #(.MS_CYCLES_P(MS)) dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.reg_req_in(req), .reg_rdata_out(rdata), .events_in(events),
		.channel_above_limit_in(above), .unattached_in(unatt),
		.dual_role_toggling_in(toggling), .toggle_imminent_in(imminent),
		.power_role_source_in(role_src), .rx_status_in(rx_status), .frs_sent_in(frs_sent),
		.vendor_irq_out(irq), .alert_clear_by_read_out(clr_rd),
		.phy_hard_reset_out(phy_rst), .whole_device_reset_out(dev_rst),
		.cc_sample_tick_out(tick), .toggle_source_share_out(share),
		.bist_continuous_out(bist), .frs_transmit_out(frs), .rx_thresh_out(thresh));
	initial begin
		clock_in = 1'b0;
		forever #4 clock_in = ~clock_in;
	end
	task automatic tally_and_finish();
		if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("Error at %0t: run did not finish", $time);
			tally_and_finish();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clock_in);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] unused;
		host_u.access(1'b1, a, d, unused);
	endtask
	task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host_u.access(1'b0, a, 8'h00, v);
		check(v, exp);
	endtask
	// Counts the cycles that a reset output stays high after the write that starts it.
	task automatic hold_len(input bit phy, output int n);
		n = 0;
		while (((phy ? phy_rst : dev_rst) === 1'b1) && n < 40) begin
			n++;
			@(negedge clock_in);
		end
	endtask
	task automatic count_ticks(input int n, output int k);
		k = 0;
		repeat (n) begin
			@(negedge clock_in);
			if (tick === 1'b1) k++;
		end
	endtask
	task automatic test_defaults();
		rd_check(ADDR_IRQ_ENABLE, 8'h00);
		rd_check(ADDR_GEN_CTRL, 8'h04);
		rd_check(ADDR_TX_CTRL, 8'h00);
		rd_check(ADDR_RX_CTRL, 8'h00);
		rd_check(ADDR_VEND_STATUS, 8'h00);
		rd_check(8'h80, 8'h00);
		check({7'h00, irq}, 8'h00);
	endtask
	task automatic test_masks();
		events = '{slow_timer: 1'b0, overtemp: 1'b1};
		idle(1);
		events = '0;
		idle(2);
		check({7'h00, irq}, 8'h00);
		rd_check(ADDR_VEND_STATUS, 8'h04);
		wr(ADDR_IRQ_ENABLE, 8'h04);
		idle(2);
		check({7'h00, irq}, 8'h01);
		wr(ADDR_VEND_STATUS, 8'h04);
		idle(2);
		rd_check(ADDR_VEND_STATUS, 8'h00);
		check({7'h00, irq}, 8'h00);
		above = 1'b1;
		idle(4);
		above = 1'b0;
		idle(4);
		rd_check(ADDR_VEND_STATUS, 8'h08);
		check({7'h00, irq}, 8'h00);
		wr(ADDR_IRQ_ENABLE, 8'h08);
		idle(2);
		check({7'h00, irq}, 8'h01);
		wr(ADDR_VEND_STATUS, 8'h18);
		rd_check(ADDR_VEND_STATUS, 8'h00);
		// A high pin while attached must leave the overvoltage flag clear.
		unatt = 1'b0;
		above = 1'b1;
		idle(4);
		above = 1'b0;
		idle(3);
		unatt = 1'b1;
		rd_check(ADDR_VEND_STATUS, 8'h00);
	endtask
	task automatic test_read_clear();
		wr(ADDR_GEN_CTRL, 8'h84);
		check({7'h00, clr_rd}, 8'h01);
		events = '{slow_timer: 1'b1, overtemp: 1'b0};
		idle(1);
		events = '0;
		idle(2);
		rd_check(ADDR_VEND_STATUS, 8'h10);
		rd_check(ADDR_VEND_STATUS, 8'h00);
		rd_check(ADDR_RX_STATUS, 8'h0A);
		rd_check(ADDR_RX_STATUS, 8'h0A);
		wr(ADDR_GEN_CTRL, 8'h04);
		check({7'h00, clr_rd}, 8'h00);
	endtask
	task automatic test_resets();
		int n;
		wr(ADDR_GEN_CTRL, 8'h44);
		hold_len(1'b1, n);
		check(8'(n), 8'(PHY_RESET_CYCLES));
		rd_check(ADDR_GEN_CTRL, 8'h04);
		wr(ADDR_IRQ_ENABLE, 8'h1C);
		wr(ADDR_TX_CTRL, 8'h04);
		wr(ADDR_GEN_CTRL, 8'h27);
		hold_len(1'b0, n);
		check(8'(n), 8'(SOFT_RESET_CYCLES));
		rd_check(ADDR_IRQ_ENABLE, 8'h00);
		rd_check(ADDR_TX_CTRL, 8'h00);
		rd_check(ADDR_GEN_CTRL, 8'h04);
		wr(ADDR_IRQ_ENABLE, 8'h1C);
		rd_check(ADDR_IRQ_ENABLE, 8'h1C);
	endtask
	task automatic test_fields();
		logic [7:0] sexp[4] = '{8'h1E, 8'h0A, 8'h32, 8'h3C};
		logic [7:0] texp[4] = '{8'h00, 8'h05, 8'h0A, 8'h01};
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_GEN_CTRL, 8'h04 | 8'(c));
			idle(2);
			check({1'b0, share}, sexp[c]);
			wr(ADDR_RX_CTRL, 8'h04 | 8'(c));
			idle(2);
			check({4'h0, thresh}, texp[c]);
		end
		wr(ADDR_RX_CTRL, 8'h03);
		role_src = 1'b1;
		idle(2);
		check({4'h0, thresh}, 8'h05);
		role_src = 1'b0;
		idle(2);
		check({4'h0, thresh}, 8'h00);
		wr(ADDR_TX_CTRL, 8'h04);
		idle(1);
		check({7'h00, bist}, 8'h01);
		wr(ADDR_TX_CTRL, 8'h02);
		idle(1);
		check({7'h00, bist}, 8'h00);
		check({7'h00, frs}, 8'h01);
		rd_check(ADDR_TX_CTRL, 8'h02);
		frs_sent = 1'b1;
		idle(1);
		frs_sent = 1'b0;
		idle(2);
		check({7'h00, frs}, 8'h00);
	endtask
	task automatic test_sampling();
		int mult[4] = '{1, 2, 8, 16};
		int k;
		toggling = 1'b1;
		for (int r = 0; r < 4; r++) begin
			wr(ADDR_GEN_CTRL, 8'(r << 2));
			idle(mult[r] * MS + 2);
			count_ticks(2 * mult[r] * MS, k);
			check(8'(k), 8'h02);
		end
		wr(ADDR_GEN_CTRL, 8'h10);
		count_ticks(60, k);
		check(8'(k), 8'h00);
		imminent = 1'b1;
		idle(1);
		imminent = 1'b0;
		check({7'h00, tick}, 8'h01);
		count_ticks(3, k);
		check(8'(k), 8'h00);
	endtask
	initial begin
		{above, toggling, imminent, role_src, frs_sent} = '0;
		unatt = 1'b1;
		rx_status = 4'hA;
		events = '0;
		rst_n_in = 1'b0;
		repeat (4) @(posedge clock_in);
		@(negedge clock_in);
		rst_n_in = 1'b1;
		test_defaults();
		test_masks();
		test_read_clear();
		test_resets();
		test_fields();
		test_sampling();
		tally_and_finish();
	end
endmodule
